// File: core/ucwb_pkg.sv
package ucwb_pkg;
    // ==========================================================
    // Geometry
    localparam int LINES = 256;
    localparam int WAYS = 4;
    localparam int LINE_WORDS = 4;
    localparam int IDX_W = 6;
    localparam int TAG_W = 22;
    localparam int WB_WORDS = 8;
    localparam int WB_ADDRS = 4;
    // ==========================================================
    // Control coprocessor
    localparam logic [3:0] CP_CTRL = 4'hf;
    localparam logic [3:0] CP_REG_ID = 4'h0;
    localparam logic [3:0] CP_REG_CTL = 4'h1;
    localparam logic [3:0] CP_REG_FLUSH = 4'h7;
    localparam logic [3:0] CP_REG_LAST = 4'h7;
    localparam int CTL_MMU = 0;
    localparam int CTL_CACHE = 2;
    localparam int CTL_WBUF = 3;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic [7:0] LFSR_SEED = 8'h5a;
    // ==========================================================
    // States and carriers
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_RD = 5'h02,
        S_FILL = 5'h04,
        S_WDRAIN = 5'h08,
        S_WEXT = 5'h10
    } ucwb_state_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic lock;
        logic seq;
        logic cacheable;
        logic bufferable;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ucwb_core_req_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [3:0] num;
        logic [3:0] sel;
        logic [31:0] wdata;
    } ucwb_cp_req_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic lock;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ucwb_mem_req_t;
endpackage : ucwb_pkg

// File: core/ucwb_top.sv
module ucwb_top #(
    parameter logic [3:0] FPU_CP_A = 4'h1,
    parameter logic [3:0] FPU_CP_B = 4'h2,
    parameter logic [31:0] ID_VALUE = 32'h0000_1234 // Arbitrary identity value.
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Core access port.
    input wire ucwb_pkg::ucwb_core_req_t i_core,
    output logic o_core_ack,
    output logic [31:0] o_core_rdata,
    // Control coprocessor port.
    input wire ucwb_pkg::ucwb_cp_req_t i_cp,
    output logic [31:0] o_cp_rdata,
    output logic o_undef_trap,
    output logic o_mmu_enable,
    // External memory port.
    output ucwb_pkg::ucwb_mem_req_t o_mem,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata
);
    import ucwb_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        ucwb_state_t state;
        logic [31:0] ctl;
        logic [LINES-1:0] vld;
        logic ack;
        logic [31:0] rdata;
        logic trap;
        logic [31:0] cp_rdata;
        logic [1:0] wcnt;
        logic [1:0] victim;
        logic lock_hold;
        logic [7:0] lfsr;
        logic [WB_ADDRS-1:0][31:0] aaddr;
        logic [WB_ADDRS-1:0][3:0] anum;
        logic [1:0] ahead;
        logic [1:0] atail;
        logic [2:0] acnt;
        logic [WB_WORDS-1:0][31:0] dat;
        logic [2:0] dhead;
        logic [2:0] dtail;
        logic [3:0] dcnt;
        logic [2:0] woff;
    } ucwb_regs_t;

    ucwb_regs_t r_reg;
    ucwb_regs_t r_next;
    logic [TAG_W-1:0] tag_mem [LINES];
    logic [31:0] data_mem [LINES*LINE_WORDS];

    logic [IDX_W-1:0] idx;
    logic [TAG_W-1:0] tag;
    logic hit;
    logic [1:0] hway;
    logic post;
    logic post_acc;
    logic idle_req;
    logic buf_go;
    logic cwr_we;
    logic fill_we;
    logic tag_we;

    // Line number of a set and way.
    function automatic logic [7:0] line_at(input logic [IDX_W-1:0] s, input logic [1:0] w);
        return {s, w};
    endfunction : line_at

    assign idx = i_core.addr[9:4];
    assign tag = i_core.addr[31:10];
    assign idle_req = r_reg.state == S_IDLE && !r_reg.ack && i_core.valid;
    assign post = r_reg.ctl[CTL_WBUF] && i_core.bufferable && !i_core.lock;
    assign buf_go = r_reg.acnt != 3'd0 && (r_reg.state == S_IDLE || r_reg.state == S_WDRAIN);

    // ==========================================================
    // Lookup over the four ways of the addressed set.
    always_comb begin
        hit = 1'b0;
        hway = 2'd0;
        for (int w = 0; w < WAYS; w++) begin
            if (r_reg.ctl[CTL_CACHE] && r_reg.vld[line_at(idx, 2'(w))]
                && tag_mem[line_at(idx, 2'(w))] == tag) begin
                hit = 1'b1;
                hway = 2'(w);
            end
        end
    end

    // ==========================================================
    // Next-state logic.
    always_comb begin
        r_next = r_reg;
        r_next.ack = 1'b0;
        r_next.trap = 1'b0;
        post_acc = 1'b0;
        cwr_we = 1'b0;
        fill_we = 1'b0;
        tag_we = 1'b0;
        r_next.lfsr = {r_reg.lfsr[6:0], r_reg.lfsr[7] ^ r_reg.lfsr[5] ^ r_reg.lfsr[4] ^ r_reg.lfsr[3]};

        // Coprocessor transfers and the trap for everything unsupported.
        if (i_cp.valid) begin
            if (i_cp.num == CP_CTRL && i_cp.sel <= CP_REG_LAST) begin
                if (i_cp.write) begin
                    if (i_cp.sel == CP_REG_CTL) begin
                        r_next.ctl = i_cp.wdata;
                    end
                    if (i_cp.sel == CP_REG_FLUSH) begin
                        r_next.vld = '0;
                    end
                end else begin
                    unique case (i_cp.sel)
                        CP_REG_ID: r_next.cp_rdata = ID_VALUE;
                        CP_REG_CTL: r_next.cp_rdata = r_reg.ctl;
                        default: r_next.cp_rdata = 32'h0000_0000;
                    endcase
                end
            end else if (i_cp.num != FPU_CP_A && i_cp.num != FPU_CP_B) begin
                r_next.trap = 1'b1;
            end
        end

        // The queue writes its oldest word whenever the state is S_IDLE or S_WDRAIN.
        if (buf_go && i_mem_ack) begin
            r_next.dhead = r_reg.dhead + 3'd1;
            r_next.dcnt = r_next.dcnt - 4'd1;
            r_next.woff = r_reg.woff + 3'd1;
            if ({1'b0, r_reg.woff} + 4'd1 == r_reg.anum[r_reg.ahead]) begin
                r_next.woff = 3'd0;
                r_next.ahead = r_reg.ahead + 2'd1;
                r_next.acnt = r_next.acnt - 3'd1;
            end
        end

        // Core access sequencing.
        unique case (r_reg.state)
            S_IDLE: begin
                if (idle_req && !i_core.write) begin
                    if (hit && !i_core.lock) begin
                        r_next.rdata = data_mem[{line_at(idx, hway), i_core.addr[3:2]}];
                        r_next.ack = 1'b1;
                    end else if (r_reg.acnt == 3'd0) begin
                        if (i_core.lock || !i_core.cacheable || !r_reg.ctl[CTL_CACHE]) begin
                            r_next.state = S_RD;
                            r_next.lock_hold = i_core.lock;
                        end else begin
                            r_next.state = S_FILL;
                            r_next.wcnt = 2'd0;
                            r_next.victim = r_reg.lfsr[1:0];
                            r_next.vld[line_at(idx, r_reg.lfsr[1:0])] = 1'b0;
                        end
                    end
                end else if (idle_req && post) begin
                    if (i_core.seq && r_reg.acnt >= 3'd2 && r_reg.dcnt < 4'(WB_WORDS)) begin
                        post_acc = 1'b1;
                        r_next.anum[r_reg.atail - 2'd1] = r_reg.anum[r_reg.atail - 2'd1] + 4'd1;
                    end else if (r_reg.acnt < 3'(WB_ADDRS) && r_reg.dcnt < 4'(WB_WORDS)) begin
                        post_acc = 1'b1;
                        r_next.aaddr[r_reg.atail] = i_core.addr;
                        r_next.anum[r_reg.atail] = 4'd1;
                        r_next.atail = r_reg.atail + 2'd1;
                        r_next.acnt = r_next.acnt + 3'd1;
                    end
                    if (post_acc) begin
                        r_next.dat[r_reg.dtail] = i_core.wdata;
                        r_next.dtail = r_reg.dtail + 3'd1;
                        r_next.dcnt = r_next.dcnt + 4'd1;
                        r_next.ack = 1'b1;
                        cwr_we = hit;
                    end
                end else if (idle_req) begin
                    r_next.state = S_WDRAIN;
                end
            end
            S_WDRAIN: begin
                if (r_reg.acnt == 3'd0) begin
                    r_next.state = S_WEXT;
                end
            end
            S_WEXT: begin
                if (i_mem_ack) begin
                    r_next.ack = 1'b1;
                    r_next.state = S_IDLE;
                    r_next.lock_hold = 1'b0;
                    cwr_we = hit;
                end
            end
            S_RD: begin
                if (i_mem_ack) begin
                    r_next.rdata = i_mem_rdata;
                    r_next.ack = 1'b1;
                    r_next.state = S_IDLE;
                end
            end
            S_FILL: begin
                if (i_mem_ack) begin
                    fill_we = 1'b1;
                    r_next.wcnt = r_reg.wcnt + 2'd1;
                    if (r_reg.wcnt == i_core.addr[3:2]) begin
                        r_next.rdata = i_mem_rdata;
                    end
                    if (r_reg.wcnt == 2'd3) begin
                        tag_we = 1'b1;
                        r_next.vld[line_at(idx, r_reg.victim)] = 1'b1;
                        r_next.ack = 1'b1;
                        r_next.state = S_IDLE;
                    end
                end
            end
            default: r_next.state = S_IDLE;
        endcase
    end

    // ==========================================================
    // Register the state; reset empties the cache and the queue.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            r_reg <= '0;
            r_reg.state <= S_IDLE;
            r_reg.ctl <= CTL_RESET;
            r_reg.lfsr <= LFSR_SEED;
        end else begin
            r_reg <= r_next;
        end
    end

    // Tag and data arrays, written on refill and on write hits.
    always_ff @(posedge i_clk) begin
        if (fill_we) begin
            data_mem[{line_at(idx, r_reg.victim), r_reg.wcnt}] <= i_mem_rdata;
        end
        if (tag_we) begin
            tag_mem[line_at(idx, r_reg.victim)] <= tag;
        end
        if (cwr_we) begin
            data_mem[{line_at(idx, hway), i_core.addr[3:2]}] <= i_core.wdata;
        end
    end

    // ==========================================================
    // Outputs; the memory port belongs to the queue unless the core owns it.
    assign o_core_ack = r_reg.ack;
    assign o_core_rdata = r_reg.rdata;
    assign o_cp_rdata = r_reg.cp_rdata;
    assign o_undef_trap = r_reg.trap;
    assign o_mmu_enable = r_reg.ctl[CTL_MMU];

    always_comb begin
        o_mem.lock = r_reg.lock_hold;
        o_mem.write = 1'b1;
        o_mem.valid = buf_go;
        o_mem.addr = r_reg.aaddr[r_reg.ahead] + {27'd0, r_reg.woff, 2'b00};
        o_mem.wdata = r_reg.dat[r_reg.dhead];
        if (r_reg.state == S_RD || r_reg.state == S_FILL) begin
            o_mem.valid = 1'b1;
            o_mem.write = 1'b0;
            o_mem.addr = i_core.addr;
            if (r_reg.state == S_FILL) begin
                o_mem.addr = {i_core.addr[31:4], r_reg.wcnt, 2'b00};
            end
        end else if (r_reg.state == S_WEXT) begin
            o_mem.valid = 1'b1;
            o_mem.addr = i_core.addr;
            o_mem.wdata = i_core.wdata;
        end
    end

    // ==========================================================
    // Checks.
    chk_reset_state: assert property (@(posedge i_clk) $fell(i_sys_rst) |->
        r_reg.vld == '0 && !r_reg.ctl[CTL_CACHE] && !r_reg.ctl[CTL_WBUF] && r_reg.acnt == 3'd0)
        else $error("reset left cache or queue active");
    chk_fill_words: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (r_reg.state == S_FILL && i_mem_ack) |=> (r_reg.state == S_FILL) == ($past(r_reg.wcnt) != 2'd3))
        else $error("line fill did not take four words");
    chk_uncached_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (r_reg.state == S_RD && !i_cp.valid) |=> $stable(r_reg.vld))
        else $error("uncached read changed the cache");
    chk_locked_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (idle_req && !i_core.write && i_core.lock) |=> !r_reg.ack
        && (r_reg.state == S_RD || $past(r_reg.acnt) != 3'd0))
        else $error("locked read served from cache");
    chk_lock_span: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (o_mem.lock && r_reg.state != S_WEXT) |=> o_mem.lock)
        else $error("lock dropped between phases");
    chk_slot_limits: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        r_reg.dcnt <= 4'(WB_WORDS) && r_reg.acnt <= 3'(WB_ADDRS) && {1'b0, r_reg.acnt} <= r_reg.dcnt)
        else $error("write queue slot count broken");
    chk_post_fast: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        post_acc |=> r_reg.ack && r_reg.state == S_IDLE)
        else $error("posted write not acknowledged next cycle");
    chk_full_stall: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (idle_req && i_core.write && post && r_reg.dcnt == 4'(WB_WORDS)) |=> !r_reg.ack)
        else $error("write accepted into a full queue");
    chk_unbuf_path: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (idle_req && i_core.write && !post) |=> r_reg.state == S_WDRAIN)
        else $error("unbuffered write was posted");
    chk_drained: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        r_reg.state == S_WEXT |-> r_reg.acnt == 3'd0)
        else $error("unbuffered write overtook queued writes");
    chk_flush_all: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_cp.valid && i_cp.write && i_cp.num == CP_CTRL && i_cp.sel == CP_REG_FLUSH
        && r_reg.state != S_FILL) |=> r_reg.vld == '0)
        else $error("flush left valid lines");
    chk_undef_trap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_cp.valid && i_cp.num != CP_CTRL && i_cp.num != FPU_CP_A && i_cp.num != FPU_CP_B) |=> o_undef_trap)
        else $error("unsupported coprocessor op did not trap");

endmodule : ucwb_top

// File: verification/ucwb_mem_model.sv
// ==========================================================
// External memory model: answers one word at a time after a set wait.
module ucwb_mem_model
    import ucwb_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Request from the block and wait setting.
    input wire ucwb_pkg::ucwb_mem_req_t i_mem,
    input wire logic [7:0] i_delay,
    // Answer to the block.
    output logic o_mem_ack,
    output logic [31:0] o_mem_rdata,
    // Log of completed words.
    output logic [31:0] o_rd_cnt,
    output logic [31:0] o_wr_cnt,
    output logic [31:0] o_waddr,
    output logic [31:0] o_wdata,
    output logic o_lock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_reg;
    // Acks one word after the wait, logs it, and churns the data lines otherwise.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wait_reg <= 8'h00;
            o_mem_ack <= 1'b0;
            o_lock <= 1'b0;
            {o_mem_rdata, o_rd_cnt, o_wr_cnt, o_waddr, o_wdata} <= '0;
        end else begin
            o_mem_ack <= 1'b0;
            o_mem_rdata <= ~o_mem_rdata; // Released data never holds its last value.
            if (i_mem.valid && !o_mem_ack) begin
                wait_reg <= wait_reg + 8'h01;
                if (wait_reg >= i_delay) begin
                    wait_reg <= 8'h00;
                    o_mem_ack <= 1'b1;
                    o_lock <= i_mem.lock;
                    if (i_mem.write) begin
                        o_wr_cnt <= o_wr_cnt + 32'h1;
                        o_waddr <= i_mem.addr;
                        o_wdata <= i_mem.wdata;
                    end else begin
                        o_rd_cnt <= o_rd_cnt + 32'h1;
                        o_mem_rdata <= i_mem.addr ^ 32'h5a5a_a5a5;
                    end
                end
            end
        end
    end
endmodule : ucwb_mem_model

// File: verification/unified_cache_write_buffer_test.sv
// ==========================================================
// Self-checking bench for the cache and posted write queue.
module unified_cache_write_buffer_test import ucwb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ID = 32'h0000_abcd; // Arbitrary identity value.
    localparam logic [31:0] A = 32'h0000_1000;
    localparam logic [31:0] B = 32'h0000_2000;
    localparam logic [31:0] P = 32'h0000_4000;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    ucwb_core_req_t i_core = '0;
    ucwb_cp_req_t i_cp = '0;
    ucwb_mem_req_t o_mem;
    logic o_core_ack, o_mmu_enable, o_undef_trap, mem_ack, mem_lock, t;
    logic [31:0] o_core_rdata, o_cp_rdata, mem_rdata, rd_cnt, wr_cnt, waddr, wdata, r0, w0;
    logic [7:0] delay = 8'h01;
    logic [11:0] traps [7] = '{12'hf00, 12'hf81, 12'hff1, 12'h301, 12'he01, 12'h100, 12'h200};
    int n;
    int miscompares = 0;
    int comparisons = 0;

    // Free-running 50 MHz clock.
    always #10 i_clk = ~i_clk;

    ucwb_top #(.ID_VALUE(ID)) uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_core(i_core),
        .o_core_ack(o_core_ack), .o_core_rdata(o_core_rdata), .i_cp(i_cp), .o_cp_rdata(o_cp_rdata),
        .o_undef_trap(o_undef_trap), .o_mmu_enable(o_mmu_enable), .o_mem(o_mem),
        .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata));
    ucwb_mem_model mem (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mem(o_mem), .i_delay(delay),
        .o_mem_ack(mem_ack), .o_mem_rdata(mem_rdata), .o_rd_cnt(rd_cnt), .o_wr_cnt(wr_cnt),
        .o_waddr(waddr), .o_wdata(wdata), .o_lock(mem_lock));

    // ==========================================================
    // Tasks
    task automatic end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Holds one core request until its ack and returns the edges waited.
    task automatic core(input logic wr, input logic lk, input logic sq, input logic c, input logic b,
        input logic [31:0] a, input logic [31:0] d, output int cnt);
        @(negedge i_clk);
        i_core = '{1'b1, wr, lk, sq, c, b, a, d};
        cnt = 0;
        do begin
            @(posedge i_clk);
            #1;
            cnt++;
        end while (o_core_ack !== 1'b1 && cnt < 400);
        if (cnt >= 400) miscompares++;
        @(negedge i_clk);
        i_core.valid = 1'b0;
    endtask : core

    // One coprocessor pulse; the trap output is sampled a cycle later.
    task automatic cp(input logic wr, input logic [3:0] num, input logic [3:0] sel, input logic [31:0] d,
        output logic trap);
        @(negedge i_clk);
        i_cp = '{1'b1, wr, num, sel, d};
        @(negedge i_clk);
        i_cp.valid = 1'b0;
        trap = o_undef_trap;
    endtask : cp

    function automatic logic [31:0] mw(input logic [31:0] a);
        return a ^ 32'h5a5a_a5a5;
    endfunction : mw

    // ==========================================================
    // Watchdog cuts a hang short.
    initial begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        end_sim();
    end

    // ==========================================================
    // Test sequence
    initial begin
        repeat (10) @(posedge i_clk);
        @(negedge i_clk);
        i_sys_rst = 1'b0;
        check(o_mem.valid, 1'b0);
        cp(1'b0, 4'hf, 4'h1, 32'h0, t);
        check(o_cp_rdata, CTL_RESET);
        foreach (traps[k]) begin
            cp(1'b0, traps[k][11:8], traps[k][7:4], 32'h0, t);
            check(t, traps[k][0]);
        end
        cp(1'b1, 4'hf, 4'h1, 32'h0000_000d, t); // Translation on in the same write
        cp(1'b0, 4'hf, 4'h1, 32'h0, t);
        check(o_cp_rdata, 32'h0000_000d);
        check(o_mmu_enable, 1'b1);
        cp(1'b0, 4'hf, 4'h0, 32'h0, t);
        check(o_cp_rdata, ID);
        // Fill on a cacheable miss, then hit even with the flag clear.
        r0 = rd_cnt;
        core(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, A + 32'h8, 32'h0, n);
        check(o_core_rdata, mw(A + 32'h8));
        check(rd_cnt - r0, 32'h4);
        core(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, A + 32'h4, 32'h0, n);
        check(o_core_rdata, mw(A + 32'h4));
        check(rd_cnt - r0, 32'h4);
        check(n, 1);
        // Uncacheable misses go out every time.
        repeat (2) core(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, B, 32'h0, n); // Aliased page kept uncacheable
        check(o_core_rdata, mw(B));
        check(rd_cnt - r0, 32'h6);
        // Unbuffered write hit goes through and updates the line.
        w0 = wr_cnt;
        core(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, A + 32'h4, 32'h1111_2222, n);
        check(wr_cnt - w0, 32'h1);
        check(waddr, A + 32'h4);
        core(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, A + 32'h4, 32'h0, n);
        check(o_core_rdata, 32'h1111_2222);
        check(rd_cnt - r0, 32'h6);
        // Write miss does not allocate.
        core(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, B + 32'h100, 32'h5, n);
        core(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, B + 32'h100, 32'h0, n);
        check(rd_cnt - r0, 32'ha);
        // Locked sequence on a cached word.
        core(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, A + 32'h4, 32'h0, n);
        check(o_core_rdata, mw(A + 32'h4));
        check(o_mem.lock, 1'b1);
        check(mem_lock, 1'b1);
        w0 = wr_cnt;
        core(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, A + 32'h4, 32'h3333_4444, n);
        check(wr_cnt - w0, 32'h1);
        check(mem_lock, 1'b1);
        core(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, A + 32'h4, 32'h0, n);
        check(o_core_rdata, 32'h3333_4444);
        check(o_mem.lock, 1'b0);
        // Flush empties the cache at once.
        cp(1'b1, 4'hf, 4'h7, 32'h0, t);
        r0 = rd_cnt;
        core(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, A + 32'h4, 32'h0, n);
        check(rd_cnt - r0, 32'h4);
        // Three singles and a five-word burst fill the queue without a stall.
        delay = 8'd20;
        w0 = wr_cnt;
        for (int k = 0; k < 8; k++) begin
            core(1'b1, 1'b0, k > 3, 1'b1, 1'b1, P + 32'(k < 4 ? 16 * k : 36 + 4 * k), 32'(k), n);
            check(n, 1);
        end
        core(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, P + 32'h80, 32'h9, n);
        check(n > 2, 1'b1);
        core(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, P + 32'h90, 32'ha, n);
        check(wr_cnt - w0, 32'ha);
        check(waddr, P + 32'h90);
        // Queued writes survive the enable being cleared.
        w0 = wr_cnt;
        repeat (2) core(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, P + 32'ha0, 32'hb, n);
        cp(1'b1, 4'hf, 4'h1, 32'h0000_0005, t);
        core(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, P + 32'hb0, 32'hc, n);
        check(wr_cnt - w0, 32'h3);
        check(wdata, 32'hc);
        // A reset in mid-run leaves every line invalid and the control word cleared.
        delay = 8'h01;
        @(negedge i_clk);
        i_sys_rst = 1'b1;
        repeat (3) @(negedge i_clk);
        i_sys_rst = 1'b0;
        cp(1'b0, 4'hf, 4'h1, 32'h0, t);
        check(o_cp_rdata, CTL_RESET);
        cp(1'b1, 4'hf, 4'h1, 32'h0000_0005, t);
        core(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, A + 32'h4, 32'h0, n);
        check(rd_cnt, 32'h4);
        check(o_core_rdata, mw(A + 32'h4));
        // Cache turned off by clearing its bit, then flushing.
        cp(1'b1, 4'hf, 4'h1, 32'h0000_0001, t);
        cp(1'b1, 4'hf, 4'h7, 32'h0, t);
        r0 = rd_cnt;
        core(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, A + 32'h4, 32'h0, n);
        check(rd_cnt - r0, 32'h1);
        check(o_core_rdata, mw(A + 32'h4));
        end_sim();
    end
endmodule : unified_cache_write_buffer_test
